// ### rtl/ssc_pkg.sv
/*
 * shared constants of the sensor conditioner command link: command codes,
 * nvm word map and field layout, status byte, controller register map.
 * assumes a single clock and byte-wide command codes.
 */
package ssc_pkg;
    // command codes
    localparam logic [7:0] CMD_CMD_MODE = 8'ha9;
    localparam logic [7:0] CMD_SLEEP = 8'ha8;
    localparam logic [7:0] CMD_CYCLIC = 8'hab;
    localparam logic [7:0] CMD_WRITE_CRC = 8'h39;
    localparam logic [7:0] CMD_RAW_BRIDGE = 8'ha2;
    localparam logic [7:0] CMD_FULL_BRIDGE = 8'haa;
    localparam logic [7:0] CMD_ADC_DIAG = 8'h51;
    localparam logic [7:0] CMD_DAC_DIAG = 8'h52;
    localparam logic [7:0] CMD_SENSOR_CHECK = 8'h53;
    localparam logic [7:0] CMD_NVM_WRITE = 8'h40;
    localparam logic [7:0] CMD_NVM_READ = 8'h41;
    // command argument layout
    localparam int ARG_ADDR_LSB = 16;
    localparam int ADDR_W = 6;
    localparam int WORD_W = 16;
    localparam int DIAG_CODE_W = 5;
    localparam int NVM_DEPTH = 64;
    // nvm word map
    localparam logic [5:0] NVM_CHECK_EN = 6'h21;
    localparam logic [5:0] NVM_BRIDGE_SLOT = 6'h22;
    localparam logic [5:0] NVM_TEMP_SLOT = 6'h23;
    localparam logic [5:0] NVM_CHECK_SLOT = 6'h24;
    localparam logic [5:0] NVM_DAC_GAIN = 6'h25;
    localparam logic [5:0] NVM_DAC_OFFSET = 6'h26;
    localparam logic [5:0] NVM_MEAS_CFG = 6'h27;
    localparam logic [5:0] NVM_MODE_CFG = 6'h28;
    localparam logic [5:0] NVM_CRC = 6'h35;
    localparam logic [5:0] NVM_LAST_CRC_WORD = 6'h34;
    localparam int MODE_CFG_CYCLIC = 0;
    localparam int CHECK_W = 12;
    // slot word fields
    localparam int SLOT_EN = 0;
    localparam int SLOT_FIRST = 1;
    localparam int SLOT_PAUSE = 2;
    localparam int PAUSE_W = 10;
    localparam logic [9:0] BRIDGE_PAUSE_MASK = 10'h00f;
    localparam logic [9:0] TEMP_PAUSE_MASK = 10'h03f;
    localparam logic [9:0] CHECK_PAUSE_MASK = 10'h3ff;
    // crc
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_SEED = 16'hffff;
    localparam int GAIN_SHIFT = 15;
    // operating modes and measurement kinds
    localparam logic [1:0] MODE_CMD = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_CYCLIC = 2'h2;
    localparam logic [1:0] KIND_BRIDGE = 2'h0;
    localparam logic [1:0] KIND_TEMP = 2'h1;
    localparam logic [1:0] KIND_CHECK = 2'h2;
    localparam logic [1:0] KIND_ADC_DIAG = 2'h3;
    // status byte bits
    localparam int STAT_SENSOR = 1;
    localparam int STAT_MEM_ERR = 2;
    localparam int STAT_MODE = 3;
    localparam int STAT_BUSY = 5;
    localparam int STAT_POWERED = 6;
    // controller registers, byte addresses
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ARG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RSP = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam int IRQ_RSP = 0;
    localparam int IRQ_IDLE = 1;
    localparam int IRQ_SENSOR = 2;
    localparam int IRQ_W = 3;
endpackage

// ### rtl/ssc_link_if.sv
/*
 * command link between the controller and the conditioner.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface ssc_link_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [23:0] cmd_arg;
    logic busy;
    logic [7:0] status;
    logic rsp_valid;
    logic [23:0] rsp_data;
    modport dev
    (
        input cmd_valid, cmd_code, cmd_arg,
        output busy, status, rsp_valid, rsp_data
    );
    modport host
    (
        output cmd_valid, cmd_code, cmd_arg,
        input busy, status, rsp_valid, rsp_data
    );
endinterface

// ### rtl/ssc_dev.sv
/*
 * conditioner end: command interpreter, nvm, crc, diagnostics, cyclic
 * sequencer and dac correction.
 * assumes one clock, the front end answering each meas_req with meas_done.
 */
// Operation
// - code a9 enters command mode
// - code a8 enters sleep mode
// - code ab starts cyclic measuring
// - code 39 stores memory crc at 35
// - valid stored crc clears memory error after reset
// - adc diagnostic replaces sensor path, uses meas config
// - five bit code selects diagnostic voltage step
// - dac diagnostic drives sixteen bit value out
// - dac gain/offset loaded at reset, applied
// - sensor checks need enable bits at 21
// - check outcome returned as 24-bit word
// - failed check sets sensor flag in status
// - cyclic configured device measures after power-up
// - slots have enable, first-slot, pause counts
// - raw measurements leave analog output untouched
`timescale 1ns/100ps
module ssc_dev
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // link
    ssc_link_if.dev link,
    // analog front end
    output logic meas_req,
    output logic [1:0] meas_kind,
    output logic adc_diag_en,
    output logic [4:0] adc_diag_code,
    output logic [15:0] sensor_meas_config,
    input wire logic meas_done,
    input wire logic [23:0] meas_data,
    input wire logic [11:0] check_fail,
    // analog output stage
    output logic [15:0] analog_output_pin,
    output logic dac_load
);
    typedef enum logic [2:0]
    {
        S_LOAD = 3'b000,
        S_IDLE = 3'b001,
        S_CRC = 3'b010,
        S_MEAS = 3'b011,
        S_SEQ = 3'b100
    } ssc_dev_state_e;

    typedef struct packed
    {
        ssc_dev_state_e st;
        logic [1:0] mode;
        logic [5:0] addr;
        logic [15:0] crc;
        logic mem_err;
        logic sensor_fail;
        logic [15:0] gain;
        logic [15:0] offset;
        logic [1:0] kind;
        logic to_dac;
        logic req;
        logic diag_en;
        logic [4:0] diag_code;
        logic [15:0] dac;
        logic dac_load;
        logic [23:0] rsp;
        logic rsp_valid;
        logic [2:0][9:0] pcnt;
        logic [1:0] slot;
    } ssc_dev_s;

    ssc_dev_s r;
    ssc_dev_s next_r;
    logic [15:0] nvm [ssc_pkg::NVM_DEPTH];
    logic nvm_we;
    logic [5:0] nvm_wa;
    logic [15:0] nvm_wd;
    logic accept;
    logic [11:0] fails;
    logic [15:0] slot_word;
    logic [9:0] pause;
    wire [2:0][9:0] entry_cnt;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] x;
        x = c ^ w;
        for (int i = 0; i < 16; i++)
        begin
            x = x[15] ? ((x << 1) ^ ssc_pkg::CRC_POLY) : (x << 1);
        end
        return x;
    endfunction

    function automatic logic [15:0] correct(input logic [23:0] d, input logic [15:0] g,
                                            input logic [15:0] o);
        logic [31:0] p;
        p = d[23:8] * g;
        return p[ssc_pkg::GAIN_SHIFT +: 16] + o;
    endfunction

    function automatic logic [15:0] slot_cfg(input logic [15:0] b, input logic [15:0] t,
                                             input logic [15:0] c, input logic [1:0] s);
        return (s == ssc_pkg::KIND_BRIDGE) ? b : (s == ssc_pkg::KIND_TEMP) ? t : c;
    endfunction

    function automatic logic [9:0] slot_pause(input logic [15:0] w, input logic [1:0] s);
        logic [9:0] m;
        m = (s == ssc_pkg::KIND_BRIDGE) ? ssc_pkg::BRIDGE_PAUSE_MASK :
            (s == ssc_pkg::KIND_TEMP) ? ssc_pkg::TEMP_PAUSE_MASK : ssc_pkg::CHECK_PAUSE_MASK;
        return w[ssc_pkg::SLOT_PAUSE +: ssc_pkg::PAUSE_W] & m;
    endfunction

    // nvm keeps its contents over reset; blank part reads zero
    initial
    begin
        for (int i = 0; i < ssc_pkg::NVM_DEPTH; i++)
        begin
            nvm[i] = 16'h0000;
        end
    end

    always @(posedge clk)
    begin
        if (ce && nvm_we)
        begin
            nvm[nvm_wa] <= nvm_wd;
        end
    end

    assign fails = check_fail & nvm[ssc_pkg::NVM_CHECK_EN][11:0];
    assign accept = link.cmd_valid && (r.st == S_IDLE || r.st == S_SEQ);
    assign slot_word = slot_cfg(nvm[ssc_pkg::NVM_BRIDGE_SLOT], nvm[ssc_pkg::NVM_TEMP_SLOT],
                                nvm[ssc_pkg::NVM_CHECK_SLOT], r.slot);
    assign pause = slot_pause(slot_word, r.slot);

    // pause counter start value per slot on entry to cyclic measuring
    for (genvar g = 0; g < 3; g++)
    begin : g_entry
        logic [15:0] cw;
        assign cw = slot_cfg(nvm[ssc_pkg::NVM_BRIDGE_SLOT], nvm[ssc_pkg::NVM_TEMP_SLOT],
                             nvm[ssc_pkg::NVM_CHECK_SLOT], 2'(g));
        assign entry_cnt[g] = cw[ssc_pkg::SLOT_FIRST] ? 10'h000 :
                              slot_pause(cw, 2'(g));
    end

    always_comb
    begin
        next_r = r;
        next_r.req = 1'b0;
        next_r.dac_load = 1'b0;
        next_r.rsp_valid = 1'b0;
        nvm_we = 1'b0;
        nvm_wa = link.cmd_arg[ssc_pkg::ARG_ADDR_LSB +: ssc_pkg::ADDR_W];
        nvm_wd = link.cmd_arg[15:0];
        unique case (r.st)
            S_LOAD:
            begin
                next_r.crc = crc_step(r.crc, nvm[r.addr]);
                next_r.addr = r.addr + 6'h01;
                if (r.addr == ssc_pkg::NVM_LAST_CRC_WORD)
                begin
                    next_r.mem_err = (next_r.crc != nvm[ssc_pkg::NVM_CRC]);
                    next_r.gain = nvm[ssc_pkg::NVM_DAC_GAIN];
                    next_r.offset = nvm[ssc_pkg::NVM_DAC_OFFSET];
                    if (nvm[ssc_pkg::NVM_MODE_CFG][ssc_pkg::MODE_CFG_CYCLIC])
                    begin
                        next_r.mode = ssc_pkg::MODE_CYCLIC;
                        next_r.st = S_SEQ;
                        next_r.pcnt = entry_cnt;
                    end
                    else
                    begin
                        next_r.st = S_IDLE;
                    end
                end
            end
            S_CRC:
            begin
                next_r.crc = crc_step(r.crc, nvm[r.addr]);
                next_r.addr = r.addr + 6'h01;
                if (r.addr == ssc_pkg::NVM_LAST_CRC_WORD)
                begin
                    nvm_we = 1'b1;
                    nvm_wa = ssc_pkg::NVM_CRC;
                    nvm_wd = next_r.crc;
                    next_r.st = (r.mode == ssc_pkg::MODE_CYCLIC) ? S_SEQ : S_IDLE;
                end
            end
            S_MEAS:
            begin
                if (meas_done)
                begin
                    next_r.diag_en = 1'b0;
                    next_r.rsp_valid = 1'b1;
                    next_r.rsp = meas_data;
                    if (r.kind == ssc_pkg::KIND_CHECK)
                    begin
                        next_r.rsp = {12'h000, fails};
                        next_r.sensor_fail = |fails;
                    end
                    if (r.to_dac)
                    begin
                        next_r.dac = correct(meas_data, r.gain, r.offset);
                        next_r.dac_load = 1'b1;
                    end
                    next_r.st = (r.mode == ssc_pkg::MODE_CYCLIC) ? S_SEQ : S_IDLE;
                end
            end
            S_SEQ:
            begin
                next_r.slot = (r.slot == ssc_pkg::KIND_CHECK) ? ssc_pkg::KIND_BRIDGE :
                              r.slot + 2'h1;
                if (slot_word[ssc_pkg::SLOT_EN])
                begin
                    if (r.pcnt[r.slot] != 10'h000)
                    begin
                        next_r.pcnt[r.slot] = r.pcnt[r.slot] - 10'h001;
                    end
                    else if (r.slot != ssc_pkg::KIND_CHECK ||
                             nvm[ssc_pkg::NVM_CHECK_EN] != 16'h0000)
                    begin
                        next_r.pcnt[r.slot] = pause;
                        next_r.kind = r.slot;
                        next_r.to_dac = (r.slot == ssc_pkg::KIND_BRIDGE);
                        next_r.req = 1'b1;
                        next_r.st = S_MEAS;
                    end
                end
            end
            S_IDLE:
            begin
            end
            default:
            begin
                next_r.st = S_IDLE;
            end
        endcase
        if (accept)
        begin
            next_r.st = (r.mode == ssc_pkg::MODE_CYCLIC) ? S_SEQ : S_IDLE;
            // an accepted command pre-empts a slot that would start now
            next_r.req = 1'b0;
            unique case (link.cmd_code)
                ssc_pkg::CMD_CMD_MODE:
                begin
                    next_r.mode = ssc_pkg::MODE_CMD;
                    next_r.st = S_IDLE;
                end
                ssc_pkg::CMD_SLEEP:
                begin
                    next_r.mode = ssc_pkg::MODE_SLEEP;
                    next_r.st = S_IDLE;
                end
                ssc_pkg::CMD_CYCLIC:
                begin
                    next_r.mode = ssc_pkg::MODE_CYCLIC;
                    next_r.st = S_SEQ;
                    next_r.slot = ssc_pkg::KIND_BRIDGE;
                    next_r.pcnt = entry_cnt;
                end
                ssc_pkg::CMD_WRITE_CRC:
                begin
                    next_r.crc = ssc_pkg::CRC_SEED;
                    next_r.addr = 6'h00;
                    next_r.st = S_CRC;
                end
                default:
                begin
                    if (r.mode == ssc_pkg::MODE_CMD)
                    begin
                        next_r.st = S_MEAS;
                        next_r.req = 1'b1;
                        next_r.to_dac = 1'b0;
                        unique case (link.cmd_code)
                            ssc_pkg::CMD_RAW_BRIDGE:
                                next_r.kind = ssc_pkg::KIND_BRIDGE;
                            ssc_pkg::CMD_FULL_BRIDGE:
                            begin
                                next_r.kind = ssc_pkg::KIND_BRIDGE;
                                next_r.to_dac = 1'b1;
                            end
                            ssc_pkg::CMD_ADC_DIAG:
                            begin
                                next_r.kind = ssc_pkg::KIND_ADC_DIAG;
                                next_r.diag_en = 1'b1;
                                next_r.diag_code = link.cmd_arg[4:0];
                            end
                            ssc_pkg::CMD_SENSOR_CHECK:
                            begin
                                next_r.kind = ssc_pkg::KIND_CHECK;
                                if (nvm[ssc_pkg::NVM_CHECK_EN] == 16'h0000)
                                begin
                                    next_r.st = S_IDLE;
                                    next_r.req = 1'b0;
                                end
                            end
                            default:
                            begin
                                next_r.st = S_IDLE;
                                next_r.req = 1'b0;
                                if (link.cmd_code == ssc_pkg::CMD_DAC_DIAG)
                                begin
                                    next_r.dac = link.cmd_arg[15:0];
                                    next_r.dac_load = 1'b1;
                                end
                                if (link.cmd_code == ssc_pkg::CMD_NVM_WRITE)
                                begin
                                    nvm_we = 1'b1;
                                end
                                if (link.cmd_code == ssc_pkg::CMD_NVM_READ)
                                begin
                                    next_r.rsp = {8'h00, nvm[nvm_wa]};
                                    next_r.rsp_valid = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '{st: S_LOAD, mode: ssc_pkg::MODE_CMD, crc: ssc_pkg::CRC_SEED, default: '0};
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign link.busy = !(r.st == S_IDLE || r.st == S_SEQ);
    assign link.status = {1'b0, 1'b1, link.busy, r.mode, r.mem_err, r.sensor_fail, 1'b0};
    assign link.rsp_valid = r.rsp_valid;
    assign link.rsp_data = r.rsp;
    assign meas_req = r.req;
    assign meas_kind = r.kind;
    assign adc_diag_en = r.diag_en;
    assign adc_diag_code = r.diag_code;
    assign sensor_meas_config = nvm[ssc_pkg::NVM_MEAS_CFG];
    assign analog_output_pin = r.dac;
    assign dac_load = r.dac_load;
endmodule

// ### rtl/ssc_host.sv
/*
 * controller end: apb register slave that issues link commands and
 * reports device status, responses and interrupts.
 * assumes the apb master and the device share clk.
 */
`timescale 1ns/100ps
module ssc_host
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // link
    ssc_link_if.host link
);
    typedef struct packed
    {
        logic [7:0] cmd;
        logic [23:0] arg;
        logic send;
        logic [23:0] rsp;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic busy_q;
        logic sens_q;
    } ssc_host_s;

    ssc_host_s r;
    ssc_host_s next_r;
    logic wr;
    logic mapped;
    logic [2:0] ev;

    assign wr = psel && penable && pwrite && ce;
    assign mapped = (paddr == ssc_pkg::REG_CMD) || (paddr == ssc_pkg::REG_ARG) ||
                    (paddr == ssc_pkg::REG_STATUS) || (paddr == ssc_pkg::REG_RSP) ||
                    (paddr == ssc_pkg::REG_IRQ_STAT) || (paddr == ssc_pkg::REG_IRQ_MASK);

    always_comb
    begin
        ev = 3'h0;
        ev[ssc_pkg::IRQ_RSP] = link.rsp_valid;
        ev[ssc_pkg::IRQ_IDLE] = r.busy_q && !link.busy;
        ev[ssc_pkg::IRQ_SENSOR] = !r.sens_q && link.status[ssc_pkg::STAT_SENSOR];
        next_r = r;
        next_r.send = 1'b0;
        next_r.busy_q = link.busy;
        next_r.sens_q = link.status[ssc_pkg::STAT_SENSOR];
        if (link.rsp_valid)
        begin
            next_r.rsp = link.rsp_data;
        end
        if (wr && paddr == ssc_pkg::REG_CMD)
        begin
            next_r.cmd = pwdata[7:0];
            next_r.send = 1'b1;
        end
        if (wr && paddr == ssc_pkg::REG_ARG)
        begin
            next_r.arg = pwdata[23:0];
        end
        if (wr && paddr == ssc_pkg::REG_IRQ_MASK)
        begin
            next_r.irq_mask = pwdata[2:0];
        end
        next_r.irq_stat = (r.irq_stat &
            ~((wr && paddr == ssc_pkg::REG_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | ev;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            ssc_pkg::REG_CMD: prdata = {24'h00_0000, r.cmd};
            ssc_pkg::REG_ARG: prdata = {8'h00, r.arg};
            ssc_pkg::REG_STATUS: prdata = {24'h00_0000, link.status};
            ssc_pkg::REG_RSP: prdata = {8'h00, r.rsp};
            ssc_pkg::REG_IRQ_STAT: prdata = {29'h0000_0000, r.irq_stat};
            ssc_pkg::REG_IRQ_MASK: prdata = {29'h0000_0000, r.irq_mask};
            default: prdata = 32'h0000_0000;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq = |(r.irq_stat & r.irq_mask);
    assign link.cmd_valid = r.send;
    assign link.cmd_code = r.cmd;
    assign link.cmd_arg = r.arg;
endmodule

// ### dv/ssc_chk_sva.sv
/* link checker: mode changes, busy, responses.
   assumes one clock, rstn async active low. */
`timescale 1ns/100ps
module ssc_chk_sva
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // link
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic busy,
    input wire logic [7:0] status,
    input wire logic rsp_valid,
    input wire logic [23:0] rsp_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_take(c);
        cmd_valid && !busy && cmd_code == c;
    endsequence
    AST_CMD: assert property (s_take(8'ha9) |=> status[4:3] == 2'h0)
        else $error("no command mode");
    AST_SLEEP: assert property (s_take(8'ha8) |=> status[4:3] == 2'h1)
        else $error("no sleep mode");
    AST_CYC: assert property (s_take(8'hab) |=> status[4:3] == 2'h2)
        else $error("no cyclic mode");
    AST_CRC: assert property (s_take(8'h39) |=> busy[*8])
        else $error("crc not busy");
    AST_DIAG: assert property (s_take(8'h51) ##0 status[4:3] == 2'h0 |=> busy[*2])
        else $error("diag not busy");
    AST_IGN: assert property (cmd_valid && busy ##1 busy |-> $stable(status[4:3]))
        else $error("command taken while busy");
    AST_BUSY: assert property (status[5] == busy)
        else $error("busy bit wrong");
    AST_RSP: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("response changed");
endmodule

// ### dv/ssc_diag_command_control_tb_top.sv
/* bench: host and device on one link, apb stimulus, front end stub.
   assumes a 200 MHz clk and rstn async active low. */
`timescale 1ns/100ps
module ssc_diag_command_control_tb_top;
    logic clk, rstn, ce, psel, penable, pwrite, pready, pslverr, irq, serr;
    logic meas_req, meas_done, adc_diag_en, dac_load;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] meas_kind;
    logic [4:0] adc_diag_code;
    logic [15:0] sensor_meas_config, analog_output_pin, loaded;
    logic [23:0] meas_data, seen;
    logic [11:0] check_fail;
    logic [2:0] fe_sh = 3'h0;
    logic [21:0] nv [6] = '{22'h210005, 22'h254000, 22'h260010, 22'h275a5a, 22'h22003f,
        22'h280001};
    int miscompares = 0;
    int samples_checked = 0;
    ssc_link_if link_i();
    ssc_host ssc_host_i (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link_i));
    ssc_dev ssc_dev_i (.clk(clk), .rstn(rstn), .ce(ce), .link(link_i), .meas_req(meas_req),
        .meas_kind(meas_kind), .adc_diag_en(adc_diag_en), .adc_diag_code(adc_diag_code),
        .sensor_meas_config(sensor_meas_config), .meas_done(meas_done),
        .meas_data(meas_data), .check_fail(check_fail),
        .analog_output_pin(analog_output_pin), .dac_load(dac_load));
    ssc_chk_sva ssc_chk_sva_i (.clk(clk), .rstn(rstn), .cmd_valid(link_i.cmd_valid),
        .cmd_code(link_i.cmd_code), .busy(link_i.busy), .status(link_i.status),
        .rsp_valid(link_i.rsp_valid), .rsp_data(link_i.rsp_data));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // front end answers three cycles after each request
    assign meas_done = fe_sh[2];
    always @(posedge clk)
    begin
        fe_sh <= {fe_sh[1:0], meas_req === 1'b1};
        if (meas_req === 1'b1)
            seen <= {sensor_meas_config, adc_diag_en, meas_kind, adc_diag_code};
        if (dac_load === 1'b1)
            loaded <= analog_output_pin;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [23:0] a);
        apb(1'b1, ssc_pkg::REG_ARG, {8'h00, a});
        apb(1'b1, ssc_pkg::REG_CMD, {24'h0, c});
        repeat (3) @(posedge clk);
        while (link_i.busy === 1'b1) @(posedge clk);
        @(posedge clk);
    endtask
    task automatic mode(input logic [1:0] e);
        apb(1'b0, ssc_pkg::REG_STATUS, 32'h0);
        chk(32'(q[4:3]), 32'(e));
    endtask
    task automatic boot();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (60) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #50us;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        meas_data = 24'h123400;
        check_fail = 12'h0;
        boot();
        apb(1'b0, ssc_pkg::REG_STATUS, 32'h0);
        chk(q, 32'h44);
        foreach (nv[i])
            cmd(ssc_pkg::CMD_NVM_WRITE, {2'h0, nv[i]});
        cmd(ssc_pkg::CMD_WRITE_CRC, 24'h0);
        boot();
        apb(1'b0, ssc_pkg::REG_STATUS, 32'h0);
        chk(32'(q[4:2]), 32'h4);
        repeat (40) @(posedge clk);
        chk(32'(analog_output_pin), 32'h92a);
        for (int n = 0; n < 8 && link_i.status[4:3] !== 2'h0; n++)
            cmd(ssc_pkg::CMD_CMD_MODE, 24'h0);
        mode(2'h0);
        meas_data <= 24'h200000;
        cmd(ssc_pkg::CMD_RAW_BRIDGE, 24'h0);
        chk(32'(analog_output_pin), 32'h92a);
        apb(1'b0, ssc_pkg::REG_RSP, 32'h0);
        chk(q, 32'h200000);
        cmd(ssc_pkg::CMD_FULL_BRIDGE, 24'h0);
        chk(32'(analog_output_pin), 32'h1010);
        cmd(ssc_pkg::CMD_DAC_DIAG, 24'h00ffff);
        chk(32'(analog_output_pin), 32'hffff);
        chk(32'(loaded), 32'hffff);
        for (int c = 0; c < 32; c += 31)
        begin
            cmd(ssc_pkg::CMD_ADC_DIAG, 24'(c));
            chk(32'(seen), 32'h5a5ae0 + 32'(c));
        end
        apb(1'b1, ssc_pkg::REG_IRQ_MASK, 32'h4);
        check_fail <= 12'h004;
        cmd(ssc_pkg::CMD_SENSOR_CHECK, 24'h0);
        chk(32'({link_i.status[1], irq}), 32'h3);
        apb(1'b0, ssc_pkg::REG_RSP, 32'h0);
        chk(q, 32'h4);
        apb(1'b1, ssc_pkg::REG_IRQ_STAT, 32'h4);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        cmd(ssc_pkg::CMD_NVM_WRITE, 24'h210000);
        check_fail <= 12'hfff;
        cmd(ssc_pkg::CMD_SENSOR_CHECK, 24'h0);
        chk(32'(link_i.status[1]), 32'h1);
        cmd(ssc_pkg::CMD_NVM_WRITE, 24'h210005);
        check_fail <= 12'h002;
        cmd(ssc_pkg::CMD_SENSOR_CHECK, 24'h0);
        chk(32'(link_i.status[1]), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({q[30:0], serr}, 32'h1);
        cmd(ssc_pkg::CMD_SLEEP, 24'h0);
        mode(2'h1);
        cmd(ssc_pkg::CMD_DAC_DIAG, 24'h001234);
        chk(32'(analog_output_pin), 32'hffff);
        cmd(ssc_pkg::CMD_CMD_MODE, 24'h0);
        apb(1'b1, ssc_pkg::REG_CMD, 32'h39);
        cmd(ssc_pkg::CMD_SLEEP, 24'h0);
        mode(2'h0);
        cmd(ssc_pkg::CMD_CYCLIC, 24'h0);
        mode(2'h2);
        print_verdict();
    end
endmodule
